// ### rtl/bct_timer.sv
// Basic 16-bit up-counting timer with classic Wishbone register slave
//
// Contract
// RULE1: Control bit 0 counter_run stops or enables counting on prescaled ticks.
// RULE2: Software sets counter_run itself in external clock, pause or encoder modes.
// RULE3: Select 000 pulses trigger_output on counter reset: master reset or force_update.
// RULE4: Select 001 pulses trigger_output on counter start: run set or pause input.
// RULE5: Select 010 pulses trigger_output on update events qualified by suppress/source.
// RULE6: Enable bit 8 gates DMA requests, bit 0 gates the update interrupt.
// RULE7: update_flag sets on update events, stays until software writes zero.
// RULE8: Writing 1 to force_update makes an update and clears counter; self-clearing.
// RULE9: Forced update also clears the prescaler counter in the same cycle.
// RULE10: Count register reads live counter; a write loads the counter directly.
// RULE11: Counter clock is kernel clock divided by clock_divider plus one.
// RULE12: clock_divider writes go to a buffer, loaded into use at update events.
// RULE13: reload_value sets the terminal count where the up-counter wraps.
// RULE14: Software uses full 32-bit word accesses only.
// RULE15: Software keeps reserved bits at reset value; they read back zero.
// RULE16: Counter counts 0 to reload_value, restarts at 0, updating on overflow.
// RULE17: With update_suppress, forced update or restart only reinitialises, no event.
// RULE18: With one_shot_select, counter clears and stops at the next update event.
// RULE19: Control bit 7 buffers reload_value writes until update, else immediate.
// RULE20: Interrupt follows flag and enable; DMA pulse per qualifying update event.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module bct_timer (
    input  wire logic        CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        WE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        MASTER_RESET_I,
    input  wire logic        PAUSE_TRIGGER_I,
    output logic             TRIGGER_OUTPUT_O,
    output logic             UPDATE_IRQ_O,
    output logic             UPDATE_DMA_REQ_O
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    // Assert at once, release through two flops
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic        ack_q;
    logic [31:0] dat_q;
    logic        req;
    logic        wr_fire;
    logic        wr_ctrl;
    logic        wr_mtrig;
    logic        wr_inten;
    logic        wr_flag;
    logic        wr_cnt;
    logic        wr_div;
    logic        wr_reload;
    logic        force_fire;
    logic        run_q;
    logic        supp_q;
    logic        ups_q;
    logic        one_shot_q;
    logic        rld_buf_en_q;
    logic [2:0]  mms_q;
    logic        dma_en_q;
    logic        irq_en_q;
    logic        flag_q;
    logic [15:0] cnt_q;
    logic [15:0] div_buf_q;
    logic [15:0] reload_buf_q;
    logic [15:0] reload_act_q;
    logic [15:0] reload_eff;
    logic        run_prev_q;
    logic        mrst_meta_q;
    logic        mrst_sync_q;
    logic        mrst_prev_q;
    logic        pause_meta_q;
    logic        pause_sync_q;
    logic        pause_prev_q;
    logic        mrst_pulse;
    logic        restart;
    logic        overflow;
    logic        upd_evt;
    logic        flag_evt;
    logic        irq_q;
    logic        dma_q;

    bct_core_if core ();

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    assign req = CYC_I && STB_I;
    // Write lands on the edge where the master sees ack; part words dropped
    assign wr_fire = req && WE_I && ack_q && (SEL_I == bct_pkg::BCT_SEL_FULL); // RULE14

    assign wr_ctrl   = wr_fire && (ADR_I == bct_pkg::BCT_OFS_CTRL);
    assign wr_mtrig  = wr_fire && (ADR_I == bct_pkg::BCT_OFS_MTRIG);
    assign wr_inten  = wr_fire && (ADR_I == bct_pkg::BCT_OFS_INTEN);
    assign wr_flag   = wr_fire && (ADR_I == bct_pkg::BCT_OFS_FLAG);
    assign wr_cnt    = wr_fire && (ADR_I == bct_pkg::BCT_OFS_CNT);
    assign wr_div    = wr_fire && (ADR_I == bct_pkg::BCT_OFS_DIV);
    assign wr_reload = wr_fire && (ADR_I == bct_pkg::BCT_OFS_RELOAD);
    // Only a one starts an event; a zero write does nothing
    assign force_fire = wr_fire && (ADR_I == bct_pkg::BCT_OFS_SWEV)
                        && DAT_I[bct_pkg::BCT_BIT_FORCE]; // RULE8

    // One wait state: ack one cycle after the request, dropped next cycle
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // Read data captured with ack; reserved and unmapped bits read zero
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            dat_q <= bct_pkg::BCT_RST_WORD;
        end else if (req && !ack_q) begin
            dat_q <= bct_pkg::BCT_RST_WORD; // RULE15
            unique case (ADR_I)
                bct_pkg::BCT_OFS_CTRL: begin
                    dat_q[bct_pkg::BCT_BIT_RUN]      <= run_q;
                    dat_q[bct_pkg::BCT_BIT_UPD_SUPP] <= supp_q;
                    dat_q[bct_pkg::BCT_BIT_UPD_SRC]  <= ups_q;
                    dat_q[bct_pkg::BCT_BIT_ONE_SHOT] <= one_shot_q;
                    dat_q[bct_pkg::BCT_BIT_RLD_BUF]  <= rld_buf_en_q;
                end
                bct_pkg::BCT_OFS_MTRIG: begin
                    dat_q[bct_pkg::BCT_MMS_MSB:bct_pkg::BCT_MMS_LSB] <= mms_q;
                end
                bct_pkg::BCT_OFS_INTEN: begin
                    dat_q[bct_pkg::BCT_BIT_DMA_EN] <= dma_en_q;
                    dat_q[bct_pkg::BCT_BIT_IRQ_EN] <= irq_en_q;
                end
                bct_pkg::BCT_OFS_FLAG: begin
                    dat_q[bct_pkg::BCT_BIT_FLAG] <= flag_q;
                end
                bct_pkg::BCT_OFS_CNT: begin
                    dat_q[15:0] <= cnt_q; // RULE10
                end
                bct_pkg::BCT_OFS_DIV: begin
                    dat_q[15:0] <= div_buf_q;
                end
                bct_pkg::BCT_OFS_RELOAD: begin
                    dat_q[15:0] <= reload_buf_q;
                end
                default: begin
                    dat_q <= bct_pkg::BCT_RST_WORD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Mode bits, software owned
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            supp_q       <= 1'b0;
            ups_q        <= 1'b0;
            one_shot_q   <= 1'b0;
            rld_buf_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            supp_q       <= DAT_I[bct_pkg::BCT_BIT_UPD_SUPP];
            ups_q        <= DAT_I[bct_pkg::BCT_BIT_UPD_SRC];
            one_shot_q   <= DAT_I[bct_pkg::BCT_BIT_ONE_SHOT];
            rld_buf_en_q <= DAT_I[bct_pkg::BCT_BIT_RLD_BUF];
        end
    end

    // Run bit; a software write in the same cycle beats the one-shot stop
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (wr_ctrl) begin
            run_q <= DAT_I[bct_pkg::BCT_BIT_RUN]; // RULE1
        end else if (upd_evt && one_shot_q) begin
            run_q <= 1'b0; // RULE18
        end
    end

    // Trigger select and enables
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            mms_q    <= 3'h0;
            dma_en_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (wr_mtrig) begin
                mms_q <= DAT_I[bct_pkg::BCT_MMS_MSB:bct_pkg::BCT_MMS_LSB];
            end
            if (wr_inten) begin
                dma_en_q <= DAT_I[bct_pkg::BCT_BIT_DMA_EN];
                irq_en_q <= DAT_I[bct_pkg::BCT_BIT_IRQ_EN];
            end
        end
    end

    // Divider and reload buffers take every write
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            div_buf_q    <= bct_pkg::BCT_RST_HALF;
            reload_buf_q <= bct_pkg::BCT_RST_HALF;
        end else begin
            if (wr_div) begin
                div_buf_q <= DAT_I[15:0]; // RULE12
            end
            if (wr_reload) begin
                reload_buf_q <= DAT_I[15:0]; // RULE13
            end
        end
    end

    // Reload copy in use when buffering is on
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            reload_act_q <= bct_pkg::BCT_RST_HALF;
        end else if (upd_evt) begin
            reload_act_q <= reload_buf_q; // RULE19
        end
    end

    // Unbuffered mode sees a new reload value at once
    assign reload_eff = rld_buf_en_q ? reload_act_q : reload_buf_q; // RULE19

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Both pins come from outside; logic uses the second and third flops, never the first
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            mrst_meta_q  <= 1'b0;
            mrst_sync_q  <= 1'b0;
            mrst_prev_q  <= 1'b0;
            pause_meta_q <= 1'b0;
            pause_sync_q <= 1'b0;
            pause_prev_q <= 1'b0;
        end else begin
            mrst_meta_q  <= MASTER_RESET_I;
            mrst_sync_q  <= mrst_meta_q;
            mrst_prev_q  <= mrst_sync_q;
            pause_meta_q <= PAUSE_TRIGGER_I;
            pause_sync_q <= pause_meta_q;
            pause_prev_q <= pause_sync_q;
        end
    end

    // ----------------------------------------------------------------
    // Counter and events
    // ----------------------------------------------------------------
    assign mrst_pulse = mrst_sync_q && !mrst_prev_q;
    assign restart    = force_fire || mrst_pulse;
    assign overflow   = core.tick && (cnt_q >= reload_eff); // RULE16
    // Suppress keeps the reinit but drops the event
    assign upd_evt    = !supp_q && (overflow || restart); // RULE17
    // Source select narrows which updates reach flag, DMA and trigger
    assign flag_evt   = !supp_q && (overflow || (restart && !ups_q)); // RULE5

    // Restart beats a load, a load beats counting
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= bct_pkg::BCT_RST_HALF;
        end else if (restart) begin
            cnt_q <= bct_pkg::BCT_RST_HALF; // RULE8
        end else if (wr_cnt) begin
            cnt_q <= DAT_I[15:0]; // RULE10
        end else if (overflow) begin
            cnt_q <= bct_pkg::BCT_RST_HALF; // RULE16
        end else if (core.tick) begin
            cnt_q <= cnt_q + 16'h0001; // RULE1
        end
    end

    // Flag: a new event wins over a clearing write in the same cycle
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (flag_evt) begin
            flag_q <= 1'b1; // RULE7
        end else if (wr_flag && !DAT_I[bct_pkg::BCT_BIT_FLAG]) begin
            flag_q <= 1'b0; // RULE7
        end
    end

    // Interrupt level and DMA pulse, both registered
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            dma_q <= 1'b0;
        end else begin
            irq_q <= flag_q && irq_en_q;   // RULE20 RULE6
            dma_q <= flag_evt && dma_en_q; // RULE20 RULE6
        end
    end

    // Edge detect for the start event
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_q;
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    assign core.run        = run_q;
    assign core.psc_clear  = restart; // RULE9
    assign core.psc_load   = upd_evt; // RULE12
    assign core.psc_div    = div_buf_q;
    assign core.mms        = mms_q;
    assign core.reset_evt  = restart; // RULE3
    assign core.start_evt  = (run_q && !run_prev_q)
                             || (pause_sync_q && !pause_prev_q); // RULE4
    assign core.update_evt = flag_evt;

    bct_prescaler u_presc (
        .clk_i  (CLK_I),
        .rst_ni (rst_n),
        .bus    (core)
    );

    bct_trigger u_trig (
        .clk_i  (CLK_I),
        .rst_ni (rst_n),
        .bus    (core)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign DAT_O            = dat_q;
    assign ACK_O            = ack_q;
    assign TRIGGER_OUTPUT_O = core.trigger;
    assign UPDATE_IRQ_O     = irq_q;
    assign UPDATE_DMA_REQ_O = dma_q;

endmodule : bct_timer
`default_nettype wire

// ### rtl/bct_pkg.sv
// Shared constants for the basic up-counting timer
package bct_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned BCT_ADR_W = 8;
    localparam int unsigned BCT_DAT_W = 32;
    localparam int unsigned BCT_CNT_W = 16;
    localparam logic [3:0]  BCT_SEL_FULL = 4'hf;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] BCT_OFS_CTRL   = 8'h00;
    localparam logic [7:0] BCT_OFS_MTRIG  = 8'h04;
    localparam logic [7:0] BCT_OFS_INTEN  = 8'h0c;
    localparam logic [7:0] BCT_OFS_FLAG   = 8'h10;
    localparam logic [7:0] BCT_OFS_SWEV   = 8'h14;
    localparam logic [7:0] BCT_OFS_CNT    = 8'h24;
    localparam logic [7:0] BCT_OFS_DIV    = 8'h28;
    localparam logic [7:0] BCT_OFS_RELOAD = 8'h2c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned BCT_BIT_RUN      = 0;
    localparam int unsigned BCT_BIT_UPD_SUPP = 1;
    localparam int unsigned BCT_BIT_UPD_SRC  = 2;
    localparam int unsigned BCT_BIT_ONE_SHOT = 3;
    localparam int unsigned BCT_BIT_RLD_BUF  = 7;
    localparam int unsigned BCT_MMS_LSB      = 4;
    localparam int unsigned BCT_MMS_MSB      = 6;
    localparam int unsigned BCT_BIT_DMA_EN   = 8;
    localparam int unsigned BCT_BIT_IRQ_EN   = 0;
    localparam int unsigned BCT_BIT_FLAG     = 0;
    localparam int unsigned BCT_BIT_FORCE    = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] BCT_RST_HALF = 16'h0000;
    localparam logic [31:0] BCT_RST_WORD = 32'h0000_0000;

    // Trigger output source selection
    typedef enum logic [2:0] {
        BCT_MMS_RESET  = 3'b000,
        BCT_MMS_START  = 3'b001,
        BCT_MMS_UPDATE = 3'b010
    } bct_mms_t;

endpackage : bct_pkg

// ### rtl/bct_core_if.sv
// Signals between the timer core and its prescaler and trigger helpers
`timescale 1ns/1ns
`default_nettype none
interface bct_core_if;
    logic        run;        // Counting enabled
    logic        psc_clear;  // Restart prescaler count
    logic        psc_load;   // Copy buffered divider into active copy
    logic [15:0] psc_div;    // Buffered divider value
    logic        tick;       // One counter clock tick
    logic [2:0]  mms;        // Trigger source select
    logic        reset_evt;  // Counter reset event
    logic        start_evt;  // Counter start event
    logic        update_evt; // Qualified update event
    logic        trigger;    // Registered trigger pulse

    modport core (output run, psc_clear, psc_load, psc_div, mms,
                  output reset_evt, start_evt, update_evt,
                  input tick, trigger);
    modport presc (input run, psc_clear, psc_load, psc_div, output tick);
    modport trig (input mms, reset_evt, start_evt, update_evt, output trigger);
endinterface : bct_core_if
`default_nettype wire

// ### rtl/bct_prescaler.sv
// Counter clock prescaler with buffered divider
`timescale 1ns/1ns
`default_nettype none
module bct_prescaler (
    input  wire logic clk_i,
    input  wire logic rst_ni,
    bct_core_if.presc bus
);

    logic [15:0] div_act_q;
    logic [15:0] psc_cnt_q;

    // Active divider only follows the buffer at an update event
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            div_act_q <= bct_pkg::BCT_RST_HALF;
        end else if (bus.psc_load) begin
            div_act_q <= bus.psc_div; // RULE12
        end
    end

    // Divide by value plus one; clear restarts a full period
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            psc_cnt_q <= bct_pkg::BCT_RST_HALF;
        end else if (bus.psc_clear) begin
            psc_cnt_q <= bct_pkg::BCT_RST_HALF; // RULE9
        end else if (bus.run) begin
            if (psc_cnt_q >= div_act_q) begin
                psc_cnt_q <= bct_pkg::BCT_RST_HALF; // RULE11
            end else begin
                psc_cnt_q <= psc_cnt_q + 16'h0001;
            end
        end
    end

    // Tick on the last count of each period
    assign bus.tick = bus.run && !bus.psc_clear && (psc_cnt_q >= div_act_q); // RULE11

endmodule : bct_prescaler
`default_nettype wire

// ### rtl/bct_trigger.sv
// Trigger output source selection
`timescale 1ns/1ns
`default_nettype none
module bct_trigger (
    input  wire logic clk_i,
    input  wire logic rst_ni,
    bct_core_if.trig  bus
);

    logic trig_d;
    logic trig_q;

    // Pick the event that drives the trigger
    always_comb begin
        unique case (bct_pkg::bct_mms_t'(bus.mms))
            bct_pkg::BCT_MMS_RESET:  trig_d = bus.reset_evt;  // RULE3
            bct_pkg::BCT_MMS_START:  trig_d = bus.start_evt;  // RULE4
            bct_pkg::BCT_MMS_UPDATE: trig_d = bus.update_evt; // RULE5
            default:                 trig_d = 1'b0;
        endcase
    end

    // Registered so the top output leaves a flip-flop
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
        end
    end

    assign bus.trigger = trig_q;

endmodule : bct_trigger
`default_nettype wire

// ### verif/bct_timer_props.sv
// Concurrent checks on the timer's bus, trigger, interrupt and DMA ports
`timescale 1ns/1ns
`default_nettype none
module bct_timer_props (
    input wire logic        CLK_I,
    input wire logic        RESETN_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic [3:0]  SEL_I,
    input wire logic        WE_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        MASTER_RESET_I,
    input wire logic        PAUSE_TRIGGER_I,
    input wire logic        TRIGGER_OUTPUT_O,
    input wire logic        UPDATE_IRQ_O,
    input wire logic        UPDATE_DMA_REQ_O
);
    logic       wr;
    logic       clr;
    logic       frc;
    logic [2:0] mms_q;
    logic [1:0] ctl_q;
    logic [1:0] en_q;
    // A full-word write lands at this edge; narrower ones are ignored by the slave
    assign wr  = CYC_I && STB_I && WE_I && ACK_O && SEL_I == 4'hf;
    assign clr = wr && ADR_I == 8'h10 && !DAT_I[0];
    assign frc = wr && ADR_I == 8'h14 && DAT_I[0];
    // Shadow of the fields that qualify the checks below
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mms_q <= 3'h0;
            ctl_q <= 2'h0;
            en_q  <= 2'h0;
        end else if (wr) begin
            if (ADR_I == 8'h04) mms_q <= DAT_I[6:4];
            if (ADR_I == 8'h00) ctl_q <= DAT_I[2:1];
            if (ADR_I == 8'h0c) en_q <= {DAT_I[8], DAT_I[0]};
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    reset_quiet_a: assert property (
        $rose(RESETN_I) |-> (!ACK_O && !TRIGGER_OUTPUT_O && !UPDATE_IRQ_O
        && !UPDATE_DMA_REQ_O) [*2]) else $error("output active after reset");
    ack_answer_a: assert property (
        CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack in one cycle");
    read_zero_a: assert property (
        ACK_O && !WE_I |-> DAT_O[31:16] == 16'h0) else $error("reserved bits set");
    swev_read_a: assert property (
        ACK_O && !WE_I && ADR_I == 8'h14 |-> DAT_O == 32'h0) else $error("event reg read");
    trig_reset_a: assert property (
        frc && mms_q == 3'h0 |=> TRIGGER_OUTPUT_O) else $error("no reset trigger");
    trig_update_a: assert property (
        frc && mms_q == 3'h2 && ctl_q == 2'h0 |=> TRIGGER_OUTPUT_O) else $error("no trigger");
    dma_force_a: assert property (
        frc && en_q[1] && ctl_q == 2'h0 |=> UPDATE_DMA_REQ_O) else $error("no dma request");
    dma_off_a: assert property (
        !en_q[1] && !$past(en_q[1]) |-> !UPDATE_DMA_REQ_O) else $error("dma while off");
    irq_off_a: assert property (
        !en_q[0] && !$past(en_q[0]) |-> !UPDATE_IRQ_O) else $error("irq while off");
    irq_hold_a: assert property (
        UPDATE_IRQ_O && en_q[0] && !clr && !$past(clr) |=> UPDATE_IRQ_O)
        else $error("irq dropped");
endmodule // bct_timer_props
`default_nettype wire

// ### verif/bct_slave_model.sv
// Slave logic that counts trigger pulses from the timer
`timescale 1ns/1ns
`default_nettype none
module bct_slave_model (
    input  wire logic       clk_i,
    input  wire logic       rst_ni,
    input  wire logic       trigger_i,
    output logic      [7:0] count_o
);
    // Every high cycle is a separate trigger, since pulses may come back to back
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            count_o <= 8'h00;
        end else if (trigger_i) begin
            count_o <= count_o + 8'h01;
        end
    end
endmodule // bct_slave_model
`default_nettype wire

// ### verif/tb_bct_timer.sv
// Self-checking bench for the basic up-counting timer
`timescale 1ns/1ns
`default_nettype none
module tb_bct_timer;
    logic        clk, rst_n, we, cyc, stb, mrst, pause, ack, trg, irq, dma;
    logic [7:0]  adr, ntrg;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    int          bad_count, n_compared, n, cyc_cnt, i;
    // Register rows: address, value written, value read back
    logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h0c, 8'h24, 8'h28, 8'h2c, 8'h18, 8'h10, 8'h14};
    logic [31:0] rw [9] = '{32'hff8e, 32'hffffffff, 32'hffffffff, 32'hffff0abc,
                            32'h12340001, 32'hffff0003, 32'hffffffff, 32'h0, 32'h0};
    logic [31:0] rr [9] = '{32'h8e, 32'h70, 32'h101, 32'habc, 32'h1, 32'h3, 32'h0, 32'h0, 32'h0};
    bct_timer u_bct_timer (.CLK_I(clk), .RESETN_I(rst_n), .ADR_I(adr), .DAT_I(wdat),
        .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(q), .ACK_O(ack),
        .MASTER_RESET_I(mrst), .PAUSE_TRIGGER_I(pause), .TRIGGER_OUTPUT_O(trg),
        .UPDATE_IRQ_O(irq), .UPDATE_DMA_REQ_O(dma));
    bct_slave_model u_bct_slave_model (.clk_i(clk), .rst_ni(rst_n), .trigger_i(trg),
        .count_o(ntrg));
    task automatic finish_test;
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; entered just after an edge, waits for ack with no fixed count
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr  <= a;
        we   <= w;
        wdat <= d;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = q;
        cyc  <= 1'b0;
        stb  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(rdat, e);
    endtask
    // Edges from here to the next DMA pulse; zero expectation means only resync
    task automatic wait_dma(input int e);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dma !== 1'b1);
        if (e != 0) chk(n, e);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard: the whole run needs well under a thousand cycles
    initial cyc_cnt = 0;
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000) begin
            bad_count++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, we, cyc, stb, mrst, pause, adr, wdat} = '0;
        sel = 4'hf;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 9; i++) begin
            rd(ra[i], 32'h0);
            wb(ra[i], 1'b1, rw[i]);
            rd(ra[i], rr[i]);
        end
        sel <= 4'h3;
        wb(8'h2c, 1'b1, 32'h7);
        sel <= 4'hf;
        rd(8'h2c, 32'h3);
        wb(8'h00, 1'b1, 32'h0);
        wb(8'h04, 1'b1, 32'h0);
        wb(8'h0c, 1'b1, 32'h0);
        wb(8'h14, 1'b1, 32'h1);
        wb(8'h14, 1'b1, 32'h0);
        chk(ntrg, 8'h1);
        rd(8'h24, 32'h0);
        wb(8'h10, 1'b1, 32'h1);
        rd(8'h10, 32'h1);
        wb(8'h10, 1'b1, 32'h0);
        rd(8'h10, 32'h0);
        // Master restart, then start events from the run bit and pause input
        mrst <= 1'b1;
        repeat (4) @(posedge clk);
        mrst <= 1'b0;
        wb(8'h04, 1'b1, 32'h10);
        chk(ntrg, 8'h2);
        wb(8'h00, 1'b1, 32'h1);
        pause <= 1'b1;
        repeat (4) @(posedge clk);
        pause <= 1'b0;
        wb(8'h00, 1'b1, 32'h0);
        chk(ntrg, 8'h4);
        wb(8'h24, 1'b1, 32'h5);
        repeat (20) @(posedge clk);
        rd(8'h24, 32'h5);
        wb(8'h04, 1'b1, 32'h20);
        wb(8'h0c, 1'b1, 32'h101);
        wb(8'h14, 1'b1, 32'h1);
        wb(8'h00, 1'b1, 32'h1);
        chk(ntrg, 8'h5);
        wait_dma(0);
        wait_dma(8);
        wb(8'h28, 1'b1, 32'h2);
        wait_dma(0);
        wait_dma(12);
        chk(irq, 1'b1);
        wb(8'h0c, 1'b1, 32'h100);
        @(posedge clk);
        chk(irq, 1'b0);
        wb(8'h00, 1'b1, 32'h9);
        wait_dma(0);
        repeat (30) @(posedge clk);
        rd(8'h00, 32'h8);
        rd(8'h24, 32'h0);
        wb(8'h04, 1'b1, 32'h20);
        wb(8'h00, 1'b1, 32'h2);
        wb(8'h24, 1'b1, 32'h55);
        wb(8'h10, 1'b1, 32'h0);
        n = ntrg;
        wb(8'h14, 1'b1, 32'h1);
        rd(8'h24, 32'h0);
        rd(8'h10, 32'h0);
        chk(ntrg, n);
        finish_test();
    end
endmodule // tb_bct_timer
bind bct_timer bct_timer_props u_bct_timer_props (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
    .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .MASTER_RESET_I(MASTER_RESET_I),
    .PAUSE_TRIGGER_I(PAUSE_TRIGGER_I), .TRIGGER_OUTPUT_O(TRIGGER_OUTPUT_O),
    .UPDATE_IRQ_O(UPDATE_IRQ_O), .UPDATE_DMA_REQ_O(UPDATE_DMA_REQ_O));
`default_nettype wire
